// [core/drc_core.sv]
// Purpose: config, latency signalling, refresh and sleep control of a ddr dram
// Assumes: link pins sampled by pclk; host keeps its own link timing
// Notes: memory array data itself is not modelled
// Contract
// - reads, writes and register reads wait an initial latency before data.
// - latency count comes from config_reg_zero bits 7:4, legal 3 to 7.
// - latency field resets to 7 clocks.
// - pending refresh at access start drives strobe high and doubles latency.
// - register writes use zero latency; data follows the address phase directly.
// - strobe level never shifts where register write data is captured.
// - fixed-latency bit set: strobe always high, two latency periods.
// - fixed latency on after reset; cleared, doubling only for refresh.
// - bits 14:12 select driver impedance, reset 000.
// - writing 0 to bit 15 enters deep sleep after entry time; refresh stops.
// - deep sleep watches only select and reset; exits on select low-high pulse.
// - bit 6 of refresh_and_sleep_config selects single-ended or differential clock.
// - single-ended mode ignores the complement clock input entirely.
// - bits 4:2 limit refresh; 100 means no refresh at all.
// - writing 1 to bit 5 enters retention sleep.
// - select low ends retention sleep and clears bit 5; resets end it too.
// - bits 1:0 read-only report refresh interval, 01 4us, 10 1us.
// - refresh spread evenly, deferred until no access is active.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module drc_core import drc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drc_link_in_t link_in,
  output var drc_link_out_t link_out,
  output logic [2:0] drive_strength,
  output logic complement_clock_en,
  output logic deep_sleep_state,
  output logic retention_sleep_state
);

  logic [DRC_LINK_W-1:0] sync_q;
  drc_link_in_t ls;

  drc_sync3 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link_in),
    .q(sync_q)
  );
  assign ls = drc_link_in_t'(sync_q);

  // registers
  logic [15:0] cr0_r;
  logic [15:0] cr0_nxt;
  logic [15:0] cr1_r;
  logic [15:0] cr1_nxt;
  logic [31:0] prdata_r;
  logic clk_prev_r;
  logic cs_prev_r;
  drc_state_t st_r;
  drc_state_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [47:0] ca_r;
  logic [47:0] ca_nxt;
  logic [3:0] lat_cnt_r;
  logic [3:0] lat_cnt_nxt;
  logic [3:0] lat_tgt_r;
  logic [3:0] lat_tgt_nxt;
  logic strobe_hi_r;
  logic strobe_hi_nxt;
  logic is_read_r;
  logic is_read_nxt;
  logic is_reg_r;
  logic is_reg_nxt;
  logic sel_cr1_r;
  logic sel_cr1_nxt;
  logic [7:0] wbuf_r;
  logic [7:0] wbuf_nxt;
  logic lnk_we;
  logic dpd_r;
  logic [4:0] dpd_cnt_r;
  logic ref_pend_r;
  logic ref_busy_r;
  logic [5:0] int_cnt_r;
  logic [2:0] busy_cnt_r;
  logic read_write_strobe_r;
  logic read_write_strobe_oe_n_r;
  logic [7:0] dq_r;
  logic dq_oe_n_r;
  logic read_write_strobe_nxt;
  logic read_write_strobe_oe_n_nxt;
  logic [7:0] dq_nxt;
  logic dq_oe_n_nxt;

  // hardware reset pin acts synchronously after the synchroniser
  wire hw_rst = ~ls.reset_n;

  // clock select: complement clock only looked at in differential mode
  wire clk_se = cr1_r[DRC_CR1_CLK_BIT];
  wire clk_diff_ok = ls.bus_clock != ls.complement_clock;
  wire clk_sel = (clk_se | clk_diff_ok) ? ls.bus_clock : clk_prev_r;
  wire clk_edge = clk_sel ^ clk_prev_r;
  wire clk_rise = clk_sel & ~clk_prev_r;
  wire cs_fall = cs_prev_r & ~ls.cs_n;
  wire cs_rise = ~cs_prev_r & ls.cs_n;

  // latency decode, illegal codes fall back to the longest
  wire [3:0] lat_field = cr0_r[DRC_CR0_LAT_LSB +: 4];
  wire lat_ok = (lat_field >= {1'b0, DRC_LAT_MIN}) && (lat_field <= {1'b0, DRC_LAT_MAX});
  wire [2:0] lat_sel = lat_ok ? lat_field[2:0] : DRC_LAT_MAX;
  wire fix_lat = cr0_r[DRC_CR0_FIX_BIT];

  // address phase decode
  wire [47:0] ca_full = {ca_r[39:0], ls.dq};
  wire ca_read = ca_full[47];
  wire ca_reg = ca_full[46];
  wire ca_cr1 = ca_full[0];
  wire [15:0] lnk_wd = {wbuf_r, ls.dq};

  // register read values
  wire [15:0] cr1_rd = cr1_r | DRC_CR1_ONES | {14'h0000, DRC_REFRESH_CODE};
  wire [15:0] link_rd = sel_cr1_r ? cr1_rd : cr0_r;
  wire in_access = (st_r != ST_IDLE) && (st_r != ST_DPD);
  wire [15:0] stat_rd = {11'h000, in_access, ref_busy_r, ref_pend_r, cr1_r[DRC_CR1_SLEEP_BIT], dpd_r};

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_cr0 = paddr == DRC_OFF_CR0;
  wire hit_cr1 = paddr == DRC_OFF_CR1;
  wire hit_stat = paddr == DRC_OFF_STAT;
  wire hit_any = hit_cr0 | hit_cr1 | hit_stat;
  wire [15:0] apb_rd = hit_cr0 ? cr0_r : (hit_cr1 ? cr1_rd : (hit_stat ? stat_rd : 16'h0000));
  wire cr0_apb_we = apb_wr & hit_cr0;
  wire cr1_apb_we = apb_wr & hit_cr1;
  wire cr0_lnk_we = lnk_we & ~sel_cr1_r;
  wire cr1_lnk_we = lnk_we & sel_cr1_r;

  // refresh bookkeeping
  wire ref_need = ~dpd_r & (cr1_r[DRC_CR1_PAR_LSB +: 3] != DRC_PAR_NONE);
  wire [5:0] int_last = (DRC_REFRESH_CODE == DRC_INT_1US) ? DRC_REF_1US_LAST : DRC_REF_4US_LAST;
  wire int_done = ref_need & (int_cnt_r == int_last);
  wire busy_start = ref_pend_r & ~ref_busy_r & ls.cs_n & (st_r == ST_IDLE);
  wire busy_done = ref_busy_r & (busy_cnt_r == DRC_REF_BUSY_LAST);
  wire dpd_enter = ~cr0_r[DRC_CR0_DPD_BIT] & ~dpd_r & (dpd_cnt_r == DRC_DPD_IN_LAST) & ls.cs_n & (st_r == ST_IDLE);
  wire dpd_exit = dpd_r & cs_rise & (st_r == ST_DPD);

  // config register next values; link write, then apb write, then hardware side effects
  always_comb begin
    cr0_nxt = cr0_r;
    if (cr0_lnk_we) begin
      cr0_nxt = lnk_wd & DRC_CR0_WMASK;
    end else if (cr0_apb_we) begin
      cr0_nxt = pwdata[15:0] & DRC_CR0_WMASK;
    end
    if (dpd_exit) begin
      cr0_nxt[DRC_CR0_DPD_BIT] = 1'b1;
    end
    cr1_nxt = cr1_r;
    if (cr1_lnk_we) begin
      cr1_nxt = lnk_wd & DRC_CR1_WMASK;
    end else if (cr1_apb_we) begin
      cr1_nxt = pwdata[15:0] & DRC_CR1_WMASK;
    end
    if (cs_fall) begin
      cr1_nxt = cr1_nxt & ~DRC_CR1_SLEEP_MASK;
    end
  end

  // link transaction sequencing
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ca_nxt = ca_r;
    lat_cnt_nxt = lat_cnt_r;
    lat_tgt_nxt = lat_tgt_r;
    strobe_hi_nxt = strobe_hi_r;
    is_read_nxt = is_read_r;
    is_reg_nxt = is_reg_r;
    sel_cr1_nxt = sel_cr1_r;
    wbuf_nxt = wbuf_r;
    lnk_we = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (dpd_r) begin
          st_nxt = ST_DPD;
        end else if (cs_fall) begin
          st_nxt = ST_CA;
          cnt_nxt = 3'h0;
          strobe_hi_nxt = fix_lat | ref_pend_r;
        end
      end
      ST_CA: begin
        if (ls.cs_n) begin
          st_nxt = ST_IDLE;
        end else if (clk_edge) begin
          ca_nxt = ca_full;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == DRC_CA_LAST) begin
            cnt_nxt = 3'h0;
            lat_cnt_nxt = 4'h0;
            is_read_nxt = ca_read;
            is_reg_nxt = ca_reg;
            sel_cr1_nxt = ca_cr1;
            if (ca_reg & ~ca_read) begin
              st_nxt = ST_WREG;
            end else begin
              lat_tgt_nxt = strobe_hi_r ? {lat_sel, 1'b0} : {1'b0, lat_sel};
              st_nxt = ST_LAT;
            end
          end
        end
      end
      ST_LAT: begin
        if (ls.cs_n) begin
          st_nxt = ST_IDLE;
        end else if (clk_rise) begin
          lat_cnt_nxt = lat_cnt_r + 4'h1;
          if (lat_cnt_r == lat_tgt_r - 4'h1) begin
            st_nxt = ST_DATA;
            cnt_nxt = 3'h0;
          end
        end
      end
      ST_WREG: begin
        if (ls.cs_n) begin
          st_nxt = ST_IDLE;
        end else if (clk_edge) begin
          wbuf_nxt = ls.dq;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == DRC_REG_LAST) begin
            lnk_we = 1'b1;
            st_nxt = ST_DATA;
            cnt_nxt = DRC_RD_DONE;
          end
        end
      end
      ST_DATA: begin
        if (ls.cs_n) begin
          st_nxt = ST_IDLE;
        end else if (clk_edge && cnt_r != DRC_RD_DONE) begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      ST_DPD: begin
        if (!dpd_r) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // pin drive: strobe during address phase, low through read latency, toggling on read data
  wire rd_drive = is_read_nxt & ((st_nxt == ST_LAT) | (st_nxt == ST_DATA));
  wire reg_rd_edge = (st_r == ST_DATA) & clk_edge & is_reg_r & is_read_r;
  always_comb begin
    read_write_strobe_oe_n_nxt = 1'b1;
    read_write_strobe_nxt = 1'b0;
    dq_oe_n_nxt = 1'b1;
    dq_nxt = dq_r;
    if (st_nxt == ST_CA) begin
      read_write_strobe_oe_n_nxt = 1'b0;
      read_write_strobe_nxt = strobe_hi_nxt;
    end else if (rd_drive) begin
      read_write_strobe_oe_n_nxt = 1'b0;
      read_write_strobe_nxt = (st_nxt == ST_DATA) & clk_sel;
    end
    if ((st_nxt == ST_DATA) & is_read_nxt & is_reg_nxt) begin
      dq_oe_n_nxt = 1'b0;
    end
    if (reg_rd_edge) begin
      dq_nxt = (cnt_r == 3'h0) ? link_rd[15:8] : ((cnt_r == 3'h1) ? link_rd[7:0] : 8'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr0_r <= DRC_CR0_RESET;
      cr1_r <= DRC_CR1_RESET;
    end else if (hw_rst) begin
      cr0_r <= DRC_CR0_RESET;
      cr1_r <= DRC_CR1_RESET;
    end else begin
      cr0_r <= cr0_nxt;
      cr1_r <= cr1_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      clk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      clk_prev_r <= clk_sel;
      cs_prev_r <= ls.cs_n;
      if (apb_setup) begin
        prdata_r <= {16'h0000, apb_rd};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      ca_r <= 48'h000000000000;
      lat_cnt_r <= 4'h0;
      lat_tgt_r <= 4'h0;
      strobe_hi_r <= 1'b0;
      is_read_r <= 1'b0;
      is_reg_r <= 1'b0;
      sel_cr1_r <= 1'b0;
      wbuf_r <= 8'h00;
    end else if (hw_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      is_read_r <= 1'b0;
      is_reg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ca_r <= ca_nxt;
      lat_cnt_r <= lat_cnt_nxt;
      lat_tgt_r <= lat_tgt_nxt;
      strobe_hi_r <= strobe_hi_nxt;
      is_read_r <= is_read_nxt;
      is_reg_r <= is_reg_nxt;
      sel_cr1_r <= sel_cr1_nxt;
      wbuf_r <= wbuf_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_write_strobe_r <= 1'b0;
      read_write_strobe_oe_n_r <= 1'b1;
      dq_r <= 8'h00;
      dq_oe_n_r <= 1'b1;
    end else if (hw_rst) begin
      read_write_strobe_oe_n_r <= 1'b1;
      dq_oe_n_r <= 1'b1;
    end else begin
      read_write_strobe_r <= read_write_strobe_nxt;
      read_write_strobe_oe_n_r <= read_write_strobe_oe_n_nxt;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
    end
  end

  // refresh timer, pending flag and busy window; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_r <= 6'h00;
      ref_pend_r <= 1'b0;
      ref_busy_r <= 1'b0;
      busy_cnt_r <= 3'h0;
    end else if (hw_rst) begin
      int_cnt_r <= 6'h00;
      ref_pend_r <= 1'b0;
      ref_busy_r <= 1'b0;
      busy_cnt_r <= 3'h0;
    end else begin
      int_cnt_r <= (int_done | ~ref_need) ? 6'h00 : int_cnt_r + 6'h01;
      ref_pend_r <= int_done | (ref_pend_r & ~busy_done & ref_need);
      ref_busy_r <= ref_need & (busy_start | (ref_busy_r & ~busy_done));
      busy_cnt_r <= ref_busy_r ? busy_cnt_r + 3'h1 : 3'h0;
    end
  end

  // deep sleep entry delay and exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpd_r <= 1'b0;
      dpd_cnt_r <= 5'h00;
    end else if (hw_rst) begin
      dpd_r <= 1'b0;
      dpd_cnt_r <= 5'h00;
    end else begin
      if (dpd_enter) begin
        dpd_r <= 1'b1;
      end else if (dpd_exit) begin
        dpd_r <= 1'b0;
      end
      if (cr0_r[DRC_CR0_DPD_BIT] | dpd_r) begin
        dpd_cnt_r <= 5'h00;
      end else if (dpd_cnt_r != DRC_DPD_IN_LAST) begin
        dpd_cnt_r <= dpd_cnt_r + 5'h01;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign link_out.read_write_strobe = read_write_strobe_r;
  assign link_out.read_write_strobe_oe_n = read_write_strobe_oe_n_r;
  assign link_out.dq_out = dq_r;
  assign link_out.dq_oe_n = dq_oe_n_r;
  assign drive_strength = cr0_r[DRC_CR0_DRV_LSB +: 3];
  assign complement_clock_en = ~clk_se;
  assign deep_sleep_state = dpd_r;
  assign retention_sleep_state = cr1_r[DRC_CR1_SLEEP_BIT];

endmodule : drc_core
`default_nettype wire

// [core/drc_pkg.sv]
// Purpose: shared constants, types and states of the dram config core
// Assumes: pclk at 10 MHz, APB register access
// Notes: link pin groups travel as packed structs
package drc_pkg;

  // apb byte offsets
  localparam logic [7:0] DRC_OFF_CR0 = 8'h00;
  localparam logic [7:0] DRC_OFF_CR1 = 8'h04;
  localparam logic [7:0] DRC_OFF_STAT = 8'h08;

  // config_reg_zero fields
  localparam int DRC_CR0_DPD_BIT = 15;
  localparam int DRC_CR0_DRV_LSB = 12;
  localparam int DRC_CR0_LAT_LSB = 4;
  localparam int DRC_CR0_FIX_BIT = 3;
  localparam logic [15:0] DRC_CR0_RESET = 16'h8078;
  localparam logic [15:0] DRC_CR0_WMASK = 16'hF0F8;

  // refresh_and_sleep_config fields
  localparam int DRC_CR1_CLK_BIT = 6;
  localparam int DRC_CR1_SLEEP_BIT = 5;
  localparam int DRC_CR1_PAR_LSB = 2;
  localparam logic [15:0] DRC_CR1_RESET = 16'h0040;
  localparam logic [15:0] DRC_CR1_WMASK = 16'h007C;
  localparam logic [15:0] DRC_CR1_ONES = 16'hFF80;
  localparam logic [15:0] DRC_CR1_SLEEP_MASK = 16'h0020;
  localparam logic [2:0] DRC_PAR_NONE = 3'h4;
  localparam logic [1:0] DRC_INT_4US = 2'h1;
  localparam logic [1:0] DRC_INT_1US = 2'h2;
  localparam logic [1:0] DRC_REFRESH_CODE = 2'h1;

  // latency
  localparam logic [2:0] DRC_LAT_MIN = 3'h3;
  localparam logic [2:0] DRC_LAT_MAX = 3'h7;

  // link framing
  localparam logic [2:0] DRC_CA_LAST = 3'h5;
  localparam logic [2:0] DRC_REG_LAST = 3'h1;
  localparam logic [2:0] DRC_RD_DONE = 3'h2;

  // timing
  localparam int DRC_CLK_NS = 100;
  localparam int DRC_REF_4US_NS = 4000;
  localparam int DRC_REF_1US_NS = 1000;
  localparam int DRC_REF_BUSY_NS = 250;
  localparam int DRC_DPD_IN_NS = 3000;
  localparam logic [5:0] DRC_REF_4US_LAST = 6'(DRC_REF_4US_NS / DRC_CLK_NS - 1);
  localparam logic [5:0] DRC_REF_1US_LAST = 6'(DRC_REF_1US_NS / DRC_CLK_NS - 1);
  localparam logic [2:0] DRC_REF_BUSY_LAST = 3'((DRC_REF_BUSY_NS + DRC_CLK_NS - 1) / DRC_CLK_NS - 1);
  localparam logic [4:0] DRC_DPD_IN_LAST = 5'(DRC_DPD_IN_NS / DRC_CLK_NS - 1);

  // link pins
  localparam int DRC_LINK_W = 12;
  localparam logic [11:0] DRC_LINK_IDLE = 12'h900;

  typedef struct packed {
    logic cs_n;
    logic bus_clock;
    logic complement_clock;
    logic reset_n;
    logic [7:0] dq;
  } drc_link_in_t;

  typedef struct packed {
    logic read_write_strobe;
    logic read_write_strobe_oe_n;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } drc_link_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CA = 3'b001,
    ST_LAT = 3'b010,
    ST_DATA = 3'b011,
    ST_WREG = 3'b100,
    ST_DPD = 3'b101
  } drc_state_t;

endpackage : drc_pkg

// [core/drc_sync3.sv]
// Purpose: three-flop synchroniser for the link pins
// Assumes: pins are asynchronous to pclk
// Notes: output follows once second and third flops agree
`timescale 1ns/100ps
`default_nettype none
module drc_sync3 import drc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DRC_LINK_W-1:0] d,
  output logic [DRC_LINK_W-1:0] q
);

  logic [DRC_LINK_W-1:0] s1_r;
  logic [DRC_LINK_W-1:0] s2_r;
  logic [DRC_LINK_W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < DRC_LINK_W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i] <= DRC_LINK_IDLE[i];
          s2_r[i] <= DRC_LINK_IDLE[i];
          s3_r[i] <= DRC_LINK_IDLE[i];
          q[i] <= DRC_LINK_IDLE[i];
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule : drc_sync3
`default_nettype wire

// [sim/drc_monitor.sv]
// Purpose: port checker for the dram config core
// Assumes: one pclk domain, presetn async active low
// Notes: bound to drc_core below
`timescale 1ns/100ps
`default_nettype none
module drc_monitor import drc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire drc_link_in_t link_in,
  input wire drc_link_out_t link_out,
  input wire logic [2:0] drive_strength,
  input wire logic complement_clock_en,
  input wire logic deep_sleep_state,
  input wire logic retention_sleep_state
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] cs_hi_r;
  logic [3:0] cs_hi_nxt;
  wire wr_any = psel && penable && pready && pwrite;
  wire wr_cr0 = wr_any && paddr == DRC_OFF_CR0;
  wire wr_cr1 = wr_any && paddr == DRC_OFF_CR1;
  // saturating count of idle select samples
  assign cs_hi_nxt = !link_in.cs_n ? 4'h0 : (cs_hi_r == 4'h8) ? cs_hi_r : cs_hi_r + 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cs_hi_r <= 4'h0;
    else cs_hi_r <= cs_hi_nxt;
  end
  sequence s_rst_low;
    (!link_in.reset_n)[*8];
  endsequence
  sequence s_quiet;
    (link_in.cs_n && link_in.reset_n)[*8];
  endsequence
  sequence s_dpd_wait;
    (!deep_sleep_state)[*8] ##[17:32] deep_sleep_state;
  endsequence
  a_drv_follow: assert property (wr_cr0 |=> drive_strength == $past(pwdata[14:12]))
    else $error("drive strength did not follow write");
  a_clk_type: assert property (wr_cr1 |=> complement_clock_en == !$past(pwdata[6]))
    else $error("clock type enable wrong after write");
  a_sleep_enter: assert property (wr_cr1 && pwdata[5] && cs_hi_r == 4'h8 |=> retention_sleep_state)
    else $error("retention sleep not entered");
  a_sleep_exit: assert property (retention_sleep_state && $fell(link_in.cs_n) |-> ##[1:6] !retention_sleep_state)
    else $error("retention sleep not left on select");
  a_dpd_entry: assert property (wr_cr0 && !pwdata[15] && cs_hi_r == 4'h8 |=> s_dpd_wait)
    else $error("deep sleep entry time wrong");
  a_dpd_exit: assert property (deep_sleep_state && $rose(link_in.cs_n) |-> ##[1:8] !deep_sleep_state)
    else $error("deep sleep not left on select pulse");
  a_dpd_hold: assert property (s_quiet ##0 deep_sleep_state |=> deep_sleep_state)
    else $error("deep sleep left without cause");
  a_link_rst: assert property (s_rst_low |-> !retention_sleep_state && !deep_sleep_state && drive_strength == 3'h0)
    else $error("link reset did not restore defaults");
endmodule : drc_monitor
bind drc_core drc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
  .link_out(link_out), .drive_strength(drive_strength), .complement_clock_en(complement_clock_en),
  .deep_sleep_state(deep_sleep_state), .retention_sleep_state(retention_sleep_state));
`default_nettype wire

// [sim/drc_host_model.sv]
// Purpose: host memory controller on the link pins
// Assumes: link clock 800 ns period, toggling only inside frames
// Notes: released dq shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module drc_host_model import drc_pkg::*; (
  output var drc_link_in_t link_in,
  input wire drc_link_out_t link_out
);
  logic diff_r;
  int rises;
  logic [10:0] smp_q[$];
  int rise_q[$];
  initial begin
    link_in = DRC_LINK_IDLE;
    diff_r = 1'b0;
    rises = 0;
  end
  // one half period; device pins sampled just before the edge
  task automatic tick(input logic [7:0] d);
    #200 link_in.dq = d;
    #190 smp_q.push_back({link_out.read_write_strobe_oe_n, link_out.read_write_strobe, link_out.dq_oe_n, link_out.dq_out});
    rise_q.push_back(rises);
    #10 link_in.bus_clock = ~link_in.bus_clock;
    link_in.complement_clock = diff_r ? ~link_in.bus_clock : link_in.bus_clock;
    if (link_in.bus_clock) rises++;
  endtask : tick
  task automatic xfer(input logic rd, input logic sel, input logic [15:0] wd, input int n_data);
    logic [7:0] d;
    smp_q.delete();
    rise_q.delete();
    #37 link_in.cs_n = 1'b0;
    link_in.complement_clock = diff_r;
    for (int i = 0; i < 6 + n_data; i++) begin
      if (i == 6) rises = 0;
      d = (i == 0) ? {rd, 7'h40} : (i == 5) ? {7'h00, sel} : (i < 5) ? 8'h00 :
        (!rd && i == 6) ? wd[15:8] : (!rd && i == 7) ? wd[7:0] : ~link_in.dq;
      tick(d);
    end
    #400 link_in.cs_n = 1'b1;
    link_in.dq = ~link_in.dq;
    // select stays high long enough to pass the pin filter
    #500;
  endtask : xfer
  task automatic cs_pulse();
    #37 link_in.cs_n = 1'b0;
    #800 link_in.cs_n = 1'b1;
  endtask : cs_pulse
  task automatic hw_reset();
    #37 link_in.reset_n = 1'b0;
    #2000 link_in.reset_n = 1'b1;
  endtask : hw_reset
endmodule : drc_host_model
`default_nettype wire

// [sim/testbench.sv]
// Purpose: self-checking bench for the dram config core
// Assumes: apb at 10 MHz, link traffic from the host model
// Notes: apb read results are matched against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module testbench import drc_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, complement_clock_en, deep_sleep_state, retention_sleep_state;
  logic [2:0] drive_strength;
  drc_link_in_t link_in;
  drc_link_out_t link_out;
  int error_cnt = 0;
  int n_checks = 0;
  int w;
  logic [31:0] lfsr = 32'hF2A61816;
  logic [32:0] exp_q[$];
  logic [31:0] r;
  logic [3:0] lat;
  logic [2:0] ds;
  drc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in), .link_out(link_out),
    .drive_strength(drive_strength), .complement_clock_en(complement_clock_en),
    .deep_sleep_state(deep_sleep_state), .retention_sleep_state(retention_sleep_state));
  drc_host_model host (.link_in(link_in), .link_out(link_out));
  always #50 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait timed out", $time);
      test_done();
    end
  endtask : bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (w = 0; w < 20; w++) begin
      @(posedge pclk);
      if (pready) break;
    end
    bound(w, 20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // apb read results, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  task automatic link_rd(input logic sel, input logic [15:0] v, input logic [1:0] sx, input logic [3:0] l);
    int k;
    logic s;
    host.xfer(1'b1, sel, 16'h0, 36);
    s = host.smp_q[5][9];
    k = -1;
    for (int i = 6; i < 41; i++) begin
      if (k < 0 && host.smp_q[i][8:0] == {1'b0, v[15:8]} && host.smp_q[i + 1][8:0] == {1'b0, v[7:0]}) k = i;
    end
    chk(33'(host.smp_q[5][10]), 33'h0);
    if (sx[1]) chk(33'(s), 33'(sx[0]));
    // data shows two samples after its launching edge
    chk(k < 0 ? 33'h1FFFFFFFF : 33'(host.rise_q[k - 1]), s ? 33'(2 * l) : 33'(l));
  endtask : link_rd
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, DRC_OFF_CR0, 32'h0, 33'h8078);
    apb(1'b0, DRC_OFF_CR1, 32'h0, 33'hFFC1);
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    chk({drive_strength, complement_clock_en, deep_sleep_state, retention_sleep_state}, 33'h0);
    $display("reset test done");
    r = rnd();
    lat = 4'(3 + r[7:0] % 5);
    ds = r[14:12];
    apb(1'b1, DRC_OFF_CR0, {r[31:16], 1'b1, ds, r[11:8], lat, 1'b1, r[2:0]}, 33'h0);
    apb(1'b0, DRC_OFF_CR0, 32'h0, {17'h1, ds, 4'h0, lat, 4'h8});
    chk(33'(drive_strength), 33'(ds));
    link_rd(1'b0, {1'b1, ds, 4'h0, lat, 4'h8}, 2'b11, lat);
    $display("fixed latency test done");
    apb(1'b1, DRC_OFF_CR1, 32'hFFD0, 33'h0);
    apb(1'b1, DRC_OFF_CR0, {16'h0, 1'b1, ds, 4'h0, lat, 4'h0}, 33'h0);
    link_rd(1'b1, 16'hFFD1, 2'b00, lat);
    repeat (50) @(posedge pclk);
    link_rd(1'b1, 16'hFFD1, 2'b10, lat);
    apb(1'b1, DRC_OFF_CR1, 32'hFFC0, 33'h0);
    for (int j = 0; j < 3; j++) begin
      repeat (8 * rnd() % 64) @(posedge pclk);
      link_rd(1'b1, 16'hFFC1, 2'b00, lat);
    end
    host.xfer(1'b0, 1'b1, 16'hFFD4, 2);
    apb(1'b0, DRC_OFF_CR1, 32'h0, 33'hFFD5);
    $display("variable latency test done");
    apb(1'b1, DRC_OFF_CR1, 32'hFF82, 33'h0);
    apb(1'b0, DRC_OFF_CR1, 32'h0, 33'hFF81);
    chk(33'(complement_clock_en), 33'h1);
    host.diff_r = 1'b1;
    link_rd(1'b1, 16'hFF81, 2'b00, lat);
    host.diff_r = 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, DRC_OFF_CR1, 32'hFFE0, 33'h0);
    @(posedge pclk);
    chk(33'(retention_sleep_state), 33'h1);
    host.cs_pulse();
    for (w = 0; w < 30 && retention_sleep_state; w++) @(posedge pclk);
    bound(w, 30);
    apb(1'b0, DRC_OFF_CR1, 32'h0, 33'hFFC1);
    $display("clock and sleep test done");
    repeat (10) @(posedge pclk);
    apb(1'b1, DRC_OFF_CR0, {16'h0, 1'b0, ds, 4'h0, lat, 4'h0}, 33'h0);
    for (w = 0; w < 60 && !deep_sleep_state; w++) @(posedge pclk);
    bound(w, 60);
    chk(33'(w > 24 && w < 41), 33'h1);
    repeat (10) @(posedge pclk);
    host.cs_pulse();
    for (w = 0; w < 30 && deep_sleep_state; w++) @(posedge pclk);
    bound(w, 30);
    apb(1'b0, DRC_OFF_CR0, 32'h0, {17'h1, ds, 4'h0, lat, 4'h0});
    apb(1'b1, DRC_OFF_CR1, 32'hFFE0, 33'h0);
    host.hw_reset();
    repeat (10) @(posedge pclk);
    apb(1'b0, DRC_OFF_CR0, 32'h0, 33'h8078);
    apb(1'b0, DRC_OFF_CR1, 32'h0, 33'hFFC1);
    chk(33'(drive_strength), 33'h0);
    $display("power down and reset test done");
    test_done();
  end
  initial begin
    #9000000;
    error_cnt++;
    $display("[ERR] %0t run timed out", $time);
    test_done();
  end
endmodule : testbench
`default_nettype wire
